// File: core/pcc_consts.vh
// constants for the port and comparator configuration block
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH
`define PCC_P3M_ANALOG_BIT 1
`define PCC_PORT_CONFIG_REG_CMPOUT_BIT 0
`define PCC_EDGE_HI_BIT 7
`define PCC_EDGE_LO_BIT 6
`define PCC_P0_MODE_IN 2'h0
`define PCC_P0_MODE_OUT 2'h1
`define PCC_P0_MODE_ADDR 2'h2
`define PCC_SYNC_RST 8'h00
`define PCC_P3_OUT_RST 4'h0
`define PCC_AUTOLATCH_EN 1'b1
`define PCC_P3_SYNC_RST 4'h0
`define PCC_ARM_RST 2'h0
`define PCC_ARM_COUNT 2'h3
`endif

// File: core/pcc_port_config.v
// port 0/2/3 pin logic with interrupt edge detection and comparator routing
`timescale 1ns/10ps
`include "pcc_consts.vh"

module pcc_port_config #(
   parameter AUTOLATCH = `PCC_AUTOLATCH_EN
) (
   input wire sys_clk,
   input wire rst_b,
   input wire [7:0] port3_mode_reg,
   input wire [7:0] port_config_reg,
   input wire [7:0] irq_edge_reg,
   input wire [1:0] p0_lo_mode,
   input wire [1:0] p0_hi_mode,
   input wire p0_open_drain,
   input wire [7:0] p2_dir_out,
   input wire p2_open_drain,
   input wire low_emi_sel,
   input wire [7:0] p0_out_data,
   input wire [7:0] p0_addr_data,
   input wire [7:0] p2_out_data,
   input wire [3:0] p3_out_data,
   input wire timer1_out,
   input wire [5:0] handshake_out,
   input wire [5:0] handshake_oe,
   input wire comparator_a_output,
   input wire comparator_b_output,
   input wire [7:0] port0_lines_in,
   output wire [7:0] port0_lines_out,
   output wire [7:0] port0_lines_oe,
   input wire [7:0] port2_lines_in,
   output wire [7:0] port2_lines_out,
   output wire [7:0] port2_lines_oe,
   input wire port3_line0,
   input wire port3_line1,
   input wire port3_line2,
   input wire port3_line3,
   output wire port3_line4,
   output wire port3_line5,
   output wire port3_line6,
   output wire port3_line7,
   output wire low_emi_drive,
   output wire [7:0] port0_hold_en,
   output wire [7:0] port2_hold_en,
   output wire port3_line0_hold_en,
   output wire analog_mode,
   output reg [7:0] port0_rd_ff,
   output reg [7:0] port2_rd_ff,
   output reg [3:0] port3_rd_ff,
   output wire timer1_ext_in,
   output wire [5:0] handshake_in,
   output reg ext_int_0,
   output reg ext_int_1,
   output reg ext_int_2,
   output reg ext_int_3
);

////////////////////////////////////////////////////////////////////////////////
// port 0 and port 2 drivers

function nib_out;
   input [1:0] mode;
   begin
      nib_out = (mode == `PCC_P0_MODE_OUT) || (mode == `PCC_P0_MODE_ADDR);
   end
endfunction

wire [7:0] p0_drive_val;
wire [7:0] p0_is_out;
wire [7:0] p0_is_addr;

assign p0_is_out = {{4{nib_out(p0_hi_mode)}}, {4{nib_out(p0_lo_mode)}}};
assign p0_is_addr = {{4{p0_hi_mode == `PCC_P0_MODE_ADDR}}, {4{p0_lo_mode == `PCC_P0_MODE_ADDR}}};
assign p0_drive_val = (p0_is_addr & p0_addr_data) | (~p0_is_addr & p0_out_data);

genvar gi;
generate
   for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      // open drain: only drive low
      assign port0_lines_out[gi] = p0_drive_val[gi];
      assign port0_lines_oe[gi] = p0_is_out[gi] & (~p0_open_drain | ~p0_drive_val[gi]);
      assign port2_lines_out[gi] = p2_out_data[gi];
      assign port2_lines_oe[gi] = p2_dir_out[gi] & (~p2_open_drain | ~p2_out_data[gi]);
   end
endgenerate

assign low_emi_drive = low_emi_sel;

wire hold_on;
assign hold_on = (AUTOLATCH != 0);
assign port0_hold_en = {8{hold_on}} & ~port0_lines_oe;
assign port2_hold_en = {8{hold_on}} & ~port2_lines_oe;
assign port3_line0_hold_en = hold_on;

////////////////////////////////////////////////////////////////////////////////
// port 3 outputs

wire cmp_out_en;
assign analog_mode = port3_mode_reg[`PCC_P3M_ANALOG_BIT];
assign cmp_out_en = port_config_reg[`PCC_PORT_CONFIG_REG_CMPOUT_BIT];

reg [3:0] p3_out_ff;
wire [3:0] nxt_p3_out;
assign nxt_p3_out[0] = cmp_out_en ? comparator_a_output
                     : (handshake_oe[3] ? handshake_out[3] : p3_out_data[0]);
assign nxt_p3_out[1] = handshake_oe[4] ? handshake_out[4] : p3_out_data[1];
assign nxt_p3_out[2] = handshake_oe[5] ? handshake_out[5] : timer1_out;
assign nxt_p3_out[3] = cmp_out_en ? comparator_b_output : p3_out_data[3];

always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      p3_out_ff <= `PCC_P3_OUT_RST;
   end else begin
      p3_out_ff <= nxt_p3_out;
   end
end

// always driven, push-pull
assign port3_line4 = p3_out_ff[0];
assign port3_line5 = p3_out_ff[1];
assign port3_line6 = p3_out_ff[2];
assign port3_line7 = p3_out_ff[3];

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

wire [3:0] p3_raw;
// in analog mode lines 1,2 are replaced by comparator results
assign p3_raw = {port3_line3,
                 analog_mode ? comparator_b_output : port3_line2,
                 analog_mode ? comparator_a_output : port3_line1,
                 port3_line0};

reg [7:0] s0_p0_ff;
reg [7:0] s1_p0_ff;
reg [7:0] s0_p2_ff;
reg [7:0] s1_p2_ff;
reg [3:0] s0_p3_ff;
reg [3:0] s1_p3_ff;
reg [3:0] d_p3_ff;
reg [3:0] pin3_s0_ff;
reg [3:0] pin3_s1_ff;

// port 0 synchroniser and read register
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      s0_p0_ff <= `PCC_SYNC_RST;
      s1_p0_ff <= `PCC_SYNC_RST;
      port0_rd_ff <= `PCC_SYNC_RST;
   end else begin
      s0_p0_ff <= port0_lines_in;
      s1_p0_ff <= s0_p0_ff;
      port0_rd_ff <= s1_p0_ff;
   end
end

// port 2 synchroniser and read register
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      s0_p2_ff <= `PCC_SYNC_RST;
      s1_p2_ff <= `PCC_SYNC_RST;
      port2_rd_ff <= `PCC_SYNC_RST;
   end else begin
      s0_p2_ff <= port2_lines_in;
      s1_p2_ff <= s0_p2_ff;
      port2_rd_ff <= s1_p2_ff;
   end
end

// port 3 event path: pin or comparator, per mode
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      s0_p3_ff <= `PCC_P3_SYNC_RST;
      s1_p3_ff <= `PCC_P3_SYNC_RST;
      d_p3_ff <= `PCC_P3_SYNC_RST;
   end else begin
      s0_p3_ff <= p3_raw;
      s1_p3_ff <= s0_p3_ff;
      d_p3_ff <= s1_p3_ff;
   end
end

// port 3 raw pins for read register bit 3, timer and handshake inputs
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      pin3_s0_ff <= `PCC_P3_SYNC_RST;
      pin3_s1_ff <= `PCC_P3_SYNC_RST;
      port3_rd_ff <= `PCC_P3_SYNC_RST;
   end else begin
      pin3_s0_ff <= {port3_line3, port3_line2, port3_line1, port3_line0};
      pin3_s1_ff <= pin3_s0_ff;
      port3_rd_ff <= {pin3_s1_ff[3], s1_p3_ff[2:0]};
   end
end

assign timer1_ext_in = pin3_s1_ff[1];
assign handshake_in = {3'h0, pin3_s1_ff[3:1]};

////////////////////////////////////////////////////////////////////////////////
// edge detection arming

// no edges until the pipeline holds real pin samples:
// reset values must never look like an edge
reg [1:0] arm_cnt_ff;
wire [1:0] nxt_arm_cnt;
wire det_armed;
assign det_armed = (arm_cnt_ff == `PCC_ARM_COUNT);
assign nxt_arm_cnt = det_armed ? arm_cnt_ff : arm_cnt_ff + 2'h1;

always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      arm_cnt_ff <= `PCC_ARM_RST;
   end else begin
      arm_cnt_ff <= nxt_arm_cnt;
   end
end

////////////////////////////////////////////////////////////////////////////////
// edge detection and interrupt mapping

wire [3:0] rise;
wire [3:0] fall;
assign rise = s1_p3_ff & ~d_p3_ff & {4{det_armed}};
assign fall = ~s1_p3_ff & d_p3_ff & {4{det_armed}};

wire e7;
wire e6;
assign e7 = irq_edge_reg[`PCC_EDGE_HI_BIT];
assign e6 = irq_edge_reg[`PCC_EDGE_LO_BIT];

// an enabled edge seen on one line
function edge_hit;
   input rise_en;
   input fall_en;
   input r;
   input f;
   begin
      edge_hit = (rise_en & r) | (fall_en & f);
   end
endfunction

reg l1_rise_en;
reg l1_fall_en;
reg l2_rise_en;
reg l2_fall_en;
always @* begin
   l1_rise_en = 1'b0;
   l1_fall_en = 1'b0;
   l2_rise_en = 1'b0;
   l2_fall_en = 1'b0;
   case ({e7, e6})
      2'h0: begin
         l1_fall_en = 1'b1;
         l2_fall_en = 1'b1;
      end
      2'h1: begin
         l1_fall_en = 1'b1;
         l2_rise_en = 1'b1;
      end
      2'h2: begin
         l1_rise_en = 1'b1;
         l2_fall_en = 1'b1;
      end
      default: begin
         l1_rise_en = 1'b1;
         l1_fall_en = 1'b1;
         l2_rise_en = 1'b1;
         l2_fall_en = 1'b1;
      end
   endcase
end

wire l1_hit;
wire l2_hit;
assign l1_hit = edge_hit(l1_rise_en, l1_fall_en, rise[1], fall[1]);
assign l2_hit = edge_hit(l2_rise_en, l2_fall_en, rise[2], fall[2]);

// one-cycle request pulses, one per enabled edge; line 3 falls give none in analog mode
always @(posedge sys_clk or negedge rst_b) begin
   if (!rst_b) begin
      ext_int_0 <= 1'b0;
      ext_int_1 <= 1'b0;
      ext_int_2 <= 1'b0;
      ext_int_3 <= 1'b0;
   end else begin
      ext_int_3 <= fall[0];
      ext_int_2 <= l1_hit;
      ext_int_0 <= l2_hit;
      ext_int_1 <= fall[3] & ~analog_mode;
   end
end

endmodule // pcc_port_config

// File: verification/pcc_board.sv
// board model: port 3 sources, comparator results and pin levels
`timescale 1ns/10ps
module pcc_board (
   input wire [5:0] pins,
   input wire [7:0] p0_out,
   input wire [7:0] p0_oe,
   input wire [7:0] p2_out,
   input wire [7:0] p2_oe,
   output wire [3:0] p3_in,
   output wire comparator_a_output,
   output wire comparator_b_output,
   output wire [7:0] port0_lines_in,
   output wire [7:0] port2_lines_in
);
   assign p3_in = pins[3:0];
   assign comparator_a_output = pins[4];
   assign comparator_b_output = pins[5];
   // released pins show the board level, never the last driven value
   assign port0_lines_in = (p0_out & p0_oe) | (8'h3C & ~p0_oe);
   assign port2_lines_in = (p2_out & p2_oe) | (8'hC3 & ~p2_oe);
endmodule // pcc_board

// File: verification/pcc_port_config_assertions.sv
// checker for the port and comparator configuration block
`timescale 1ns/10ps
module pcc_chk (
   input wire sys_clk,
   input wire rst_b,
   input wire [7:0] port3_mode_reg,
   input wire [7:0] port_config_reg,
   input wire [7:0] irq_edge_reg,
   input wire comparator_a_output,
   input wire low_emi_sel,
   input wire port3_line0,
   input wire port3_line1,
   input wire port3_line3,
   input wire port3_line4,
   input wire low_emi_drive,
   input wire analog_mode,
   input wire ext_int_1,
   input wire ext_int_2,
   input wire ext_int_3
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // synchroniser and detector delay, then a single pulse
   sequence s_pulse(irq);
      ##3 irq ##1 !irq;
   endsequence
   a_int3_fall: assert property ($fell(port3_line0) |-> s_pulse(ext_int_3)) else $error("int3 pulse missing");
   a_int1_fall: assert property ($fell(port3_line3) && !analog_mode |-> s_pulse(ext_int_1))
      else $error("int1 pulse missing");
   a_int1_quiet: assert property ($fell(port3_line3) && analog_mode |-> ##3 !ext_int_1)
      else $error("int1 pulsed in analog mode");
   a_int2_rise: assert property ($rose(port3_line1) && irq_edge_reg[7] && !analog_mode |-> s_pulse(ext_int_2))
      else $error("int2 rising edge missed");
   a_int2_fall: assert property ($fell(port3_line1) && !irq_edge_reg[7] && !analog_mode |-> s_pulse(ext_int_2))
      else $error("int2 falling edge missed");
   a_analog_sel: assert property (analog_mode == port3_mode_reg[1]) else $error("analog mode wrong");
   a_cmp_route: assert property (analog_mode && port_config_reg[0] |=> port3_line4 == $past(comparator_a_output))
      else $error("comparator not on line 4");
   a_emi_sel: assert property (low_emi_drive == low_emi_sel) else $error("low emi drive wrong");
endmodule // pcc_chk

bind pcc_port_config pcc_chk i_chk (.sys_clk, .rst_b, .port3_mode_reg, .port_config_reg, .irq_edge_reg,
   .comparator_a_output, .low_emi_sel, .port3_line0, .port3_line1, .port3_line3, .port3_line4, .low_emi_drive,
   .analog_mode, .ext_int_1, .ext_int_2, .ext_int_3);

// File: verification/pcc_port_config_tb.sv
// testbench for the port and comparator configuration block
`timescale 1ns/10ps
module pcc_port_config_tb;
   reg sys_clk = 1'b0, rst_b = 1'b0, p0_open_drain = 1'b0, p2_open_drain = 1'b0, low_emi_sel = 1'b1;
   reg timer1_out = 1'b0;
   reg [7:0] port3_mode_reg = 8'h00, port_config_reg = 8'h00, irq_edge_reg = 8'h00, p2_dir_out = 8'h00;
   reg [7:0] p0_out_data = 8'h00, p2_out_data = 8'h00, p0_addr_data = 8'hA5;
   reg [1:0] p0_lo_mode = 2'h0, p0_hi_mode = 2'h0;
   reg [3:0] p3_out_data = 4'h0;
   reg [5:0] pins = 6'h3F, handshake_out = 6'h00, handshake_oe = 6'h00;
   reg [31:0] cnt = 32'h0;
   wire [7:0] port0_lines_in, port0_lines_out, port0_lines_oe, port2_lines_in, port2_lines_out, port2_lines_oe;
   wire [7:0] port0_rd_ff, port2_rd_ff;
   wire [3:0] p3_in;
   wire port3_line4, port3_line5, port3_line6, port3_line7, comparator_a_output, comparator_b_output;
   wire low_emi_drive, timer1_ext_in, ext_int_0, ext_int_1, ext_int_2, ext_int_3;
   wire [7:0] port0_hold_en, port2_hold_en;
   wire [3:0] port3_rd_ff;
   wire [5:0] handshake_in;
   wire port3_line0_hold_en;
   integer n_fail = 0, samples_checked = 0, cyc = 0, k;
   pcc_board i_board (.pins, .p0_out(port0_lines_out), .p0_oe(port0_lines_oe), .p2_out(port2_lines_out),
      .p2_oe(port2_lines_oe), .p3_in, .comparator_a_output, .comparator_b_output, .port0_lines_in, .port2_lines_in);
   pcc_port_config i_dut (.sys_clk, .rst_b, .port3_mode_reg, .port_config_reg, .irq_edge_reg, .p0_lo_mode,
      .p0_hi_mode, .p0_open_drain, .p2_dir_out, .p2_open_drain, .low_emi_sel, .p0_out_data, .p0_addr_data,
      .p2_out_data, .p3_out_data, .timer1_out, .handshake_out, .handshake_oe, .comparator_a_output,
      .comparator_b_output, .port0_lines_in, .port0_lines_out, .port0_lines_oe, .port2_lines_in, .port2_lines_out,
      .port2_lines_oe, .port3_line0(p3_in[0]), .port3_line1(p3_in[1]), .port3_line2(p3_in[2]),
      .port3_line3(p3_in[3]), .port3_line4, .port3_line5, .port3_line6, .port3_line7, .low_emi_drive,
      .port0_hold_en, .port2_hold_en, .port3_line0_hold_en, .analog_mode(), .port0_rd_ff, .port2_rd_ff,
      .port3_rd_ff, .timer1_ext_in, .handshake_in, .ext_int_0, .ext_int_1, .ext_int_2, .ext_int_3);
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      cnt <= cnt + {7'h0, ext_int_3, 7'h0, ext_int_2, 7'h0, ext_int_1, 7'h0, ext_int_0};
      if (cyc == 1000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // all lines fall then rise; pulse counts per source in bytes 3..0
   task edges(input [31:0] exp);
      reg [31:0] base;
      begin
         base = cnt;
         pins = 6'h00;
         repeat (5) @(negedge sys_clk);
         pins = 6'h3F;
         repeat (6) @(negedge sys_clk);
         chk(cnt - base, exp);
      end
   endtask
   task final_report;
      begin
         $display("fails=%0d checks=%0d", n_fail, samples_checked);
         if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      chk({port3_line7, port3_line6, port3_line5, port3_line4, ext_int_3}, 5'h00);
      // let the sync pipeline fill with idle pin levels
      repeat (4) @(negedge sys_clk);
      for (k = 0; k < 4; k = k + 1) begin
         irq_edge_reg = {k[1:0], 6'h00};
         edges((k == 3) ? 32'h01020102 : 32'h01010101);
      end
      $display("edge test done");
      p0_lo_mode = 2'h1;
      p0_out_data = 8'h5A;
      p2_dir_out = 8'h96;
      p2_out_data = 8'h0F;
      p3_out_data = 4'h9;
      timer1_out = 1'b1;
      pins = 6'h35;
      repeat (4) @(negedge sys_clk);
      chk({port0_lines_oe, port0_rd_ff, port2_lines_oe}, 24'h0F3A96);
      chk({port3_line7, port3_line6, port3_line5, port3_line4, timer1_ext_in, low_emi_drive}, 6'h35);
      chk({port3_rd_ff, handshake_in}, 10'h142);
      chk({port0_hold_en, port2_hold_en, port3_line0_hold_en}, 17'h1E0D3);
      p0_open_drain = 1'b1;
      p2_open_drain = 1'b1;
      pins = 6'h3F;
      handshake_oe = 6'h38;
      handshake_out = 6'h10;
      low_emi_sel = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk({port0_lines_oe, port2_lines_oe, port2_rd_ff}, 24'h059043);
      chk({port3_line7, port3_line6, port3_line5, port3_line4, low_emi_drive}, 5'h14);
      p0_open_drain = 1'b0;
      p0_lo_mode = 2'h2;
      p0_hi_mode = 2'h2;
      #1 chk({port0_lines_oe, port0_lines_out}, 16'hFFA5);
      @(negedge sys_clk);
      $display("port test done");
      port3_mode_reg = 8'h02;
      irq_edge_reg = 8'hC0;
      port_config_reg = 8'h01;
      repeat (8) @(negedge sys_clk); // settle before trusting comparators
      edges(32'h01020002);
      pins = 6'h1F;
      repeat (2) @(negedge sys_clk);
      chk({port3_line7, port3_line4}, 2'h1);
      $display("analog test done");
      final_report;
   end
endmodule // pcc_port_config_tb
